// ==== rtl/tune_sleep_consts.svh ====
/*
  Offsets, field positions, reset values and factors of the tuning/clock-gate
  and modulation/sleep configuration registers.
  Assumes inclusion by bare name from design files.
*/
`ifndef TUNE_SLEEP_CONSTS_SVH
`define TUNE_SLEEP_CONSTS_SVH

// ==========================================================
// Register offsets
`define OFS_TUNE_UPPER 4'h2
`define OFS_MOD_SLEEP 4'h3

// ==========================================================
// Field positions, first register
`define TUNE_MSB 7
`define TUNE_LSB 2
`define CLKEN_BIT 1
`define CLKON_BIT 0

// ==========================================================
// Field positions, second register
`define MODSEL_BIT 7
`define SLEEP_MSB 6
`define SLEEP_LSB 2
`define SLEEPX_BIT 1
`define LIMX_BIT 0

// ==========================================================
// Reset values
`define TUNE_UPPER_RST 8'h7b
`define MOD_SLEEP_RST 8'h60

// ==========================================================
// Decode constants
`define NARROW_BASE 13'hc00
`define TUNE_STEP_SHIFT 7
`define SLEEP_TICKS 11'h400
`define SLEEP_X_ON 4'h8
`define SLEEP_X_OFF 4'h1
`define LIM_X_ON 2'h2
`define LIM_X_OFF 2'h1
`define NARROW_MAX 13'hfff

`endif

// ==== rtl/tune_sleep_pkg.sv ====
/*
  Types shared by the configuration bank.
  Assumes nothing beyond the constants header.
*/
package tune_sleep_pkg;
  // Operating modes of the transceiver
  typedef enum logic [2:0] {
    MODE_IDLE = 3'b000,
    MODE_TX = 3'b001,
    MODE_RX_POLL = 3'b010,
    MODE_RX = 3'b011,
    MODE_FD_MASTER = 3'b101,
    MODE_FD_SLAVE = 3'b111
  } op_mode_t;

  // Register write request
  typedef struct packed {
    logic wr;
    logic [3:0] addr;
    logic [7:0] data;
  } reg_wr_t;

  // Wake events that may switch the clock on
  typedef struct packed {
    logic bit_check_ok;
    logic wake_request_pin;
    logic status_power_on;
  } wake_ev_t;
endpackage : tune_sleep_pkg

// ==== rtl/clk_gate_ctl.sv ====
/*
  Clock output gate for the host clock pin.
  Assumes the divided clock arrives as a one-cycle enable-free level.
*/
`timescale 1ns/1ps
module clk_gate_ctl (
  // Control bits
  input wire logic clock_out_enable,
  input wire logic clock_on,
  input wire logic link_mode,
  // Divided clock in and pin out
  input wire logic clk_src,
  output logic clk_pin
);
  // ==========================================================
  // Gate: off when enable low, follows the source when both set in a link mode
  always_comb begin
    clk_pin = link_mode & clock_out_enable & clock_on & clk_src;
  end
endmodule : clk_gate_ctl

// ==== rtl/tune_sleep_regs.sv ====
/*
  Tuning-upper/clock-gate and modulation/sleep configuration registers.
  Assumes synchronous writes from the serial interface decoder and sync inputs.
*/
`timescale 1ns/1ps
`include "tune_sleep_consts.svh"
// How it works
// - Clock pin off unless both enables set
// - Clock-on bit set at reset; once cleared, clock stays off until a wake event or a write sets it
// - Wake pin, power-on status and, in receive modes, bit check set the clock-on bit
// - Modulation select FSK/ASK, ignored in duplex
// - Sleep interval is field times 1024 times factor
// - Sleep extend gives factor 1 or 8
// - Limit extend doubles bit-timing windows in receive modes only
// - Second register field layout
// - Thirteen-bit word from upper and lower bits
// - Narrow range word limited to 3072..4095
module tune_sleep_regs (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Register access
  input tune_sleep_pkg::reg_wr_t wr_req,
  input wire logic [3:0] rd_addr,
  output logic [7:0] rd_data,
  // Context from other registers and status
  input tune_sleep_pkg::op_mode_t op_mode,
  input wire logic pll_range_wide,
  input wire logic [6:0] tune_lower,
  input tune_sleep_pkg::wake_ev_t wake_ev,
  input wire logic clk_src,
  // Decoded outputs
  output logic clk_pin,
  output logic [12:0] carrier_word,
  output logic ask_active,
  output logic [15:0] sleep_units,
  output logic [1:0] limit_factor
);
  import tune_sleep_pkg::*;

  logic [7:0] tune_r; // Tuning upper and clock-gate register
  logic [7:0] tune_nxt;
  logic [7:0] mod_r; // Modulation and sleep register
  logic [7:0] mod_nxt;
  logic [12:0] word_nxt; // Decoded carrier word
  logic rx_mode; // Receive or receive polling
  logic link_mode; // Receive, transmit or duplex
  logic wake_any; // Any wake event
  logic [17:0] sleep_full; // Sleep interval before the cut to 16 bits

  // Upper tuning value as a function of range bit
  function automatic logic [12:0] upper_val(input logic wide, input logic [5:0] f);
    if (wide) begin
      upper_val = {f, 7'h00};
    end else begin
      upper_val = `NARROW_BASE + {3'h0, f[2:0], 7'h00};
    end
  endfunction : upper_val

  // ==========================================================
  // Mode decode
  always_comb begin
    rx_mode = (op_mode == MODE_RX) || (op_mode == MODE_RX_POLL);
    link_mode = rx_mode || (op_mode == MODE_TX) || (op_mode == MODE_FD_MASTER)
      || (op_mode == MODE_FD_SLAVE);
    wake_any = (wake_ev.bit_check_ok & rx_mode) | wake_ev.wake_request_pin
      | wake_ev.status_power_on;
  end

  // ==========================================================
  // Sleep interval: field times ticks times extension, kept wide so the
  // largest setting does not wrap before the deliberate 16-bit cut
  always_comb begin
    sleep_full = 18'(mod_r[`SLEEP_MSB:`SLEEP_LSB]) * 18'(`SLEEP_TICKS)
      * 18'(mod_r[`SLEEPX_BIT] ? `SLEEP_X_ON : `SLEEP_X_OFF);
  end

  // ==========================================================
  // Next register values: write, then wake set wins
  always_comb begin
    tune_nxt = tune_r;
    mod_nxt = mod_r;
    if (wr_req.wr && wr_req.addr == `OFS_TUNE_UPPER) begin
      tune_nxt = wr_req.data;
    end
    if (wr_req.wr && wr_req.addr == `OFS_MOD_SLEEP) begin
      mod_nxt = wr_req.data;
    end
    // Hardware set beats software clear
    if (wake_any) begin
      tune_nxt[`CLKON_BIT] = 1'b1;
    end
  end

  // Register update
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tune_r <= `TUNE_UPPER_RST;
      mod_r <= `MOD_SLEEP_RST;
    end else begin
      tune_r <= tune_nxt;
      mod_r <= mod_nxt;
    end
  end

  // ==========================================================
  // Carrier word: upper plus lower, clamped in narrow range
  always_comb begin
    word_nxt = upper_val(pll_range_wide, tune_r[`TUNE_MSB:`TUNE_LSB])
      | {6'h00, tune_lower};
    if (!pll_range_wide && word_nxt > `NARROW_MAX) begin
      word_nxt = `NARROW_MAX;
    end
  end

  // Decoded outputs registered
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      carrier_word <= 13'h0000;
      ask_active <= 1'b0;
      sleep_units <= 16'h0000;
      limit_factor <= `LIM_X_OFF;
    end else begin
      carrier_word <= word_nxt;
      // Duplex ignores modulation select
      ask_active <= mod_r[`MODSEL_BIT] && (op_mode == MODE_TX || rx_mode);
      // Units of data clock periods, top bits cut; zero outside receive
      sleep_units <= rx_mode ? sleep_full[15:0] : 16'h0000;
      limit_factor <= (rx_mode && mod_r[`LIMX_BIT]) ? `LIM_X_ON : `LIM_X_OFF;
    end
  end

  // ==========================================================
  // Read back
  always_comb begin
    case (rd_addr)
      `OFS_TUNE_UPPER: rd_data = tune_r;
      `OFS_MOD_SLEEP: rd_data = mod_r;
      default: rd_data = 8'h00;
    endcase
  end

  // Clock pin gate
  clk_gate_ctl u_gate (
    .clock_out_enable(tune_r[`CLKEN_BIT]),
    .clock_on(tune_r[`CLKON_BIT]),
    .link_mode(link_mode),
    .clk_src(clk_src),
    .clk_pin(clk_pin)
  );

  // ==========================================================
  // Checks
  property p_wake_sets;
    @(posedge sys_clk) disable iff (!resetn) wake_any |=> tune_r[`CLKON_BIT];
  endproperty
  a_wake_sets: assert property (p_wake_sets) else $error("wake did not set clock on");

  property p_clk_off;
    @(posedge sys_clk) disable iff (!resetn) !tune_r[`CLKEN_BIT] |-> !clk_pin;
  endproperty
  a_clk_off: assert property (p_clk_off) else $error("clock pin ran while disabled");

  property p_narrow;
    @(posedge sys_clk) disable iff (!resetn)
      !pll_range_wide |=> carrier_word >= `NARROW_BASE && carrier_word <= `NARROW_MAX;
  endproperty
  a_narrow: assert property (p_narrow) else $error("narrow word out of range");

  property p_fd_fsk;
    @(posedge sys_clk) disable iff (!resetn)
      (op_mode == MODE_FD_MASTER || op_mode == MODE_FD_SLAVE) |=> !ask_active;
  endproperty
  a_fd_fsk: assert property (p_fd_fsk) else $error("ask in duplex");

  property p_limx;
    @(posedge sys_clk) disable iff (!resetn)
      (rx_mode && mod_r[`LIMX_BIT]) |=> limit_factor == 2'h2;
  endproperty
  a_limx: assert property (p_limx) else $error("limit factor not doubled");

  property p_sleep_tx;
    @(posedge sys_clk) disable iff (!resetn) (op_mode == MODE_TX) |=> sleep_units == 16'h0000;
  endproperty
  a_sleep_tx: assert property (p_sleep_tx) else $error("sleep active in transmit");

  property p_wide;
    @(posedge sys_clk) disable iff (!resetn)
      pll_range_wide |=> carrier_word[12:7] == $past(tune_r[7:2]);
  endproperty
  a_wide: assert property (p_wide) else $error("wide decode wrong");

  property p_layout;
    @(posedge sys_clk) disable iff (!resetn)
      (wr_req.wr && wr_req.addr == `OFS_MOD_SLEEP) |=> mod_r == $past(wr_req.data);
  endproperty
  a_layout: assert property (p_layout) else $error("second register write lost");

  // Enabled but not yet woken: the pin must stay quiet
  property p_clk_wait;
    @(posedge sys_clk) disable iff (!resetn)
      (tune_r[`CLKEN_BIT] && !tune_r[`CLKON_BIT]) |-> !clk_pin;
  endproperty
  a_clk_wait: assert property (p_clk_wait) else $error("clock pin ran before wake");

  // Narrow range: top three field bits ignored, base of 3072
  property p_narrow_step;
    @(posedge sys_clk) disable iff (!resetn)
      !pll_range_wide |=> carrier_word[12:10] == 3'h3
      && carrier_word[9:7] == $past(tune_r[`TUNE_LSB+2:`TUNE_LSB]);
  endproperty
  a_narrow_step: assert property (p_narrow_step) else $error("narrow decode wrong");

  // Lower tuning bits pass straight into the word
  property p_lower;
    @(posedge sys_clk) disable iff (!resetn)
      ##1 carrier_word[6:0] == $past(tune_lower);
  endproperty
  a_lower: assert property (p_lower) else $error("lower tuning bits lost");

  // Plain sleep: each field step is 1024 data clock periods
  property p_sleep_plain;
    @(posedge sys_clk) disable iff (!resetn)
      (rx_mode && !mod_r[`SLEEPX_BIT]) |=>
      sleep_units == {1'b0, $past(mod_r[`SLEEP_MSB:`SLEEP_LSB]), 10'h000};
  endproperty
  a_sleep_plain: assert property (p_sleep_plain) else $error("plain sleep wrong");

  // Extended sleep: eight times longer, top bits cut to the output width
  property p_sleep_ext;
    @(posedge sys_clk) disable iff (!resetn)
      (rx_mode && mod_r[`SLEEPX_BIT]) |=>
      sleep_units == {$past(mod_r[`SLEEP_LSB+2:`SLEEP_LSB]), 13'h0000};
  endproperty
  a_sleep_ext: assert property (p_sleep_ext) else $error("extended sleep wrong");
endmodule : tune_sleep_regs

// ==== bench/host_model.sv ====
/*
  Host model: issues register writes and reads to the bank.
  Assumes sys_clk comes from the bench.
*/
`timescale 1ns/1ps
module host_model (
  // Clock
  input wire logic sys_clk,
  // Register access
  output tune_sleep_pkg::reg_wr_t wr_req,
  output logic [3:0] rd_addr,
  input wire logic [7:0] rd_data
);
  import tune_sleep_pkg::*;
  // ==========================================
  // Bus idle from time zero
  initial begin
    wr_req = '0;
    rd_addr = 4'h0;
  end
  // Whole 8-bit write, one-cycle pulse set on falling edges
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    wr_req = '{wr: 1'b1, addr: a, data: d};
    @(negedge sys_clk);
    wr_req.wr = 1'b0;
  endtask : wr
  // Read data is combinational, so sample once settled
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    rd_addr = a;
    #1 d = rd_data;
  endtask : rd
endmodule : host_model

// ==== bench/testbench.sv ====
/*
  Self-checking bench for the configuration bank.
  Assumes host_model and the design files are compiled first.
*/
`timescale 1ns/1ps
module testbench;
  import tune_sleep_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  reg_wr_t wr_req;
  logic [3:0] rd_addr;
  logic [7:0] rd_data;
  logic [7:0] r;
  op_mode_t op_mode = MODE_RX;
  logic pll_range_wide = 1'b1;
  logic [6:0] tune_lower = 7'h00;
  wake_ev_t wake_ev = '0;
  logic clk_src = 1'b1;
  logic clk_pin;
  logic ask_active;
  logic [12:0] carrier_word;
  logic [15:0] sleep_units;
  logic [1:0] limit_factor;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  // ==========================================
  // Clock and instances
  always #2 sys_clk = ~sys_clk;
  host_model host (.sys_clk(sys_clk), .wr_req(wr_req), .rd_addr(rd_addr), .rd_data(rd_data));
  tune_sleep_regs dut (.sys_clk(sys_clk), .resetn(resetn), .wr_req(wr_req),
    .rd_addr(rd_addr), .rd_data(rd_data), .op_mode(op_mode),
    .pll_range_wide(pll_range_wide), .tune_lower(tune_lower), .wake_ev(wake_ev),
    .clk_src(clk_src), .clk_pin(clk_pin), .carrier_word(carrier_word),
    .ask_active(ask_active), .sleep_units(sleep_units), .limit_factor(limit_factor));
  // ==========================================
  // Compare, wait and close
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic settle();
    repeat (2) @(negedge sys_clk);
  endtask : settle
  task automatic conclude();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  // Hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      conclude();
    end
  end
  // ==========================================
  // Scenarios
  task automatic t_reset();
    host.rd(4'h2, r);
    chk(r, 8'h7b);
    host.rd(4'h3, r);
    chk(r, 8'h60);
    chk(carrier_word, 13'hf00);
    chk(ask_active, 1'b0);
    chk(limit_factor, 2'h1);
    chk(clk_pin, 1'b1);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_mod();
    op_mode = MODE_RX_POLL;
    host.wr(4'h3, 8'hff);
    settle();
    chk(ask_active, 1'b1);
    chk(sleep_units, 16'he000);
    chk(limit_factor, 2'h2);
    host.wr(4'h3, 8'h60);
    settle();
    chk(sleep_units, 16'h6000);
    chk(ask_active, 1'b0);
    op_mode = MODE_TX;
    settle();
    chk(sleep_units, 16'h0000);
    host.wr(4'h3, 8'hff);
    op_mode = MODE_FD_MASTER;
    settle();
    chk(ask_active, 1'b0);
    chk(sleep_units, 16'h0000);
    chk(limit_factor, 2'h1);
    op_mode = MODE_FD_SLAVE;
    settle();
    chk(ask_active, 1'b0);
    op_mode = MODE_TX;
    settle();
    chk(ask_active, 1'b1);
    chk(limit_factor, 2'h1);
    host.wr(4'h3, 8'h60);
    op_mode = MODE_RX;
    $display("t_mod done");
  endtask : t_mod
  task automatic t_tune();
    pll_range_wide = 1'b0;
    tune_lower = 7'h7f;
    host.wr(4'h2, 8'hff);
    settle();
    chk(carrier_word, 13'hfff);
    tune_lower = 7'h00;
    settle();
    chk(carrier_word, 13'hf80);
    pll_range_wide = 1'b1;
    settle();
    chk(carrier_word, 13'h1f80);
    $display("t_tune done");
  endtask : t_tune
  task automatic t_clk();
    host.wr(4'h2, 8'h01);
    settle();
    chk(clk_pin, 1'b0);
    host.wr(4'h2, 8'h02);
    settle();
    chk(clk_pin, 1'b0);
    wake_ev.wake_request_pin = 1'b1;
    @(negedge sys_clk);
    wake_ev.wake_request_pin = 1'b0;
    host.rd(4'h2, r);
    chk(r, 8'h03);
    chk(clk_pin, 1'b1);
    host.wr(4'h2, 8'h02);
    host.rd(4'h2, r);
    chk(r, 8'h02);
    @(negedge sys_clk);
    wake_ev.bit_check_ok = 1'b1;
    @(negedge sys_clk);
    wake_ev.bit_check_ok = 1'b0;
    host.rd(4'h2, r);
    chk(r, 8'h03);
    // Wake held across a clearing write: the set must win
    @(negedge sys_clk);
    wake_ev.status_power_on = 1'b1;
    host.wr(4'h2, 8'h02);
    wake_ev.status_power_on = 1'b0;
    host.rd(4'h2, r);
    chk(r, 8'h03);
    host.wr(4'h9, 8'h00);
    host.rd(4'h9, r);
    chk(r, 8'h00);
    host.rd(4'h2, r);
    chk(r, 8'h03);
    // Bit check outside receive must not wake the clock
    @(negedge sys_clk);
    op_mode = MODE_TX;
    host.wr(4'h2, 8'h02);
    wake_ev.bit_check_ok = 1'b1;
    @(negedge sys_clk);
    wake_ev.bit_check_ok = 1'b0;
    host.rd(4'h2, r);
    chk(r, 8'h02);
    @(negedge sys_clk);
    op_mode = MODE_RX;
    // Pin follows the source only while gated on, and is off in idle
    host.wr(4'h2, 8'h03);
    clk_src = 1'b0;
    @(negedge sys_clk);
    chk(clk_pin, 1'b0);
    clk_src = 1'b1;
    op_mode = MODE_IDLE;
    @(negedge sys_clk);
    chk(clk_pin, 1'b0);
    op_mode = MODE_RX;
    @(negedge sys_clk);
    chk(clk_pin, 1'b1);
    $display("t_clk done");
  endtask : t_clk
  initial begin
    repeat (6) @(negedge sys_clk);
    resetn = 1'b1;
    settle();
    t_reset();
    t_mod();
    t_tune();
    t_clk();
    conclude();
  end
endmodule : testbench
